// File: rtl/trd_regs.svh
// field positions, encodings and timing counts of the receive stream framer
`ifndef TRD_REGS_SVH
`define TRD_REGS_SVH

// header dword 0, lowest header byte in bits 31:24
`define TRD_FMT_DATA_BIT 30
`define TRD_FMT_FOUR_BIT 29
`define TRD_TYPE_HI 28
`define TRD_TYPE_LO 24
`define TRD_MSG_HI 28
`define TRD_MSG_LO 27
`define TRD_MSG_CODE 2'h2
`define TRD_TYPE_CPLD 5'h0A

// address dword (request) or lower address byte (completion)
`define TRD_QW_ADDR_BIT 2

// index of the last header dword
`define TRD_HDR_LAST_THREE 3'h2
`define TRD_HDR_LAST_FOUR 3'h3

// ready latency in cycles
`define TRD_READY_LATENCY 2

// slot count up to which a 128-bit word leaves its upper qword void
`define TRD_VOID_LIMIT 2

`endif

// File: rtl/trd_pkg.sv
// types shared by the receive stream framer
package trd_pkg;

  typedef enum logic [1:0] {
    TRD_PH_HDR,
    TRD_PH_PAD,
    TRD_PH_PAY
  } trd_phase_type;

endpackage : trd_pkg

// File: rtl/trd_lane_order.sv
// byte order of one dword as it is placed on the stream
`timescale 1ns/1ns
`default_nettype none

module trd_lane_order (
  // incoming dword, lowest numbered byte in bits 31:24
  input wire logic [31:0] dword_in,
  input wire logic payload_sel,
  // dword in stream lane order
  output logic [31:0] dword_out
);

  logic [31:0] swapped;

  // payload dword n: byte 4n+3 in the first position, 4n last
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_byte
      assign swapped[8*gi +: 8] = dword_in[8*(3-gi) +: 8]; // [R3]
    end
  endgenerate

  // header dwords keep ascending byte order
  assign dword_out = payload_sel ? swapped : dword_in; // [R2]

endmodule : trd_lane_order

`default_nettype wire

// File: rtl/trd_rx_framer.sv
// receive stream framer: packs tlp dwords into qword-aligned stream words
//
// Behaviour
// [R1] messages are laid out like packets with a four-dword header
// [R2] header words carry four header bytes ascending, lowest byte first
// [R3] payload dword n carries bytes 4n+3, 4n+2, 4n+1, 4n in that order
// [R4] payload is always address aligned, even when no real address exists
// [R5] payload aligned to 64-bit qwords; unaligned start shifted within qword
// [R6] byte lanes in the skipped leading dword are undefined, left as zero
// [R7] request payload placement follows bit 2 of the request address
// [R8] completion payload placement follows bit 2 of the lower address
// [R9] address translation bits are never checked, no malformed flag
// [R10] stream word width is 64 or 128 bits
// [R11] first flag rises with valid only on a packet's first word
// [R12] last flag rises with valid only on a packet's final word
// [R13] in 128-bit mode a void flag marks an empty upper qword
// [R14] the sink raises accept when it can take data, drops it to throttle
// [R15] accept at cycle n makes n+2 a ready cycle; valid only then
// [R16] valid drops within 2 clocks of accept dropping, returns within 2
// [R17] buffer ecc error raises the error flag while valid is high
`timescale 1ns/1ns
`default_nettype none
`include "trd_regs.svh"

module trd_rx_framer #(
  parameter int DATA_W = 64
) (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // dwords from the transaction layer
  input wire logic [31:0] tl_dword,
  input wire logic tl_dword_valid,
  input wire logic tl_dword_first,
  input wire logic tl_dword_last,
  input wire logic tl_ecc_err,
  output logic tl_dword_ready,
  // stream towards the application
  output logic [DATA_W-1:0] rx_stream_payload,
  output logic rx_packet_first,
  output logic rx_packet_last,
  output logic rx_upper_qword_void,
  output logic rx_word_valid,
  output logic rx_uncorrectable_flag,
  input wire logic rx_sink_accept
);

  import trd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // sizes

  localparam int K = DATA_W / 32;
  localparam int CW = $clog2(K + 1);
  localparam int LAT = `TRD_READY_LATENCY;
  localparam logic [CW-1:0] K_CNT = CW'(K);
  localparam logic [CW-1:0] ONE_CNT = CW'(1);
  localparam logic [CW-1:0] VOID_CNT = CW'(`TRD_VOID_LIMIT);

  generate
    if (DATA_W != 64 && DATA_W != 128) begin : g_bad_width
      $error("trd_rx_framer: DATA_W must be 64 or 128"); // [R10]
    end
  endgenerate

  typedef struct packed {
    trd_phase_type phase;
    logic [DATA_W-1:0] acc;
    logic [CW-1:0] cnt;
    logic acc_first;
    logic acc_last;
    logic acc_err;
    logic acc_done;
    logic [2:0] hdr_idx;
    logic hdr_four;
    logic hdr_msg;
    logic has_data;
    logic align;
    logic [DATA_W-1:0] out_data;
    logic out_first;
    logic out_last;
    logic out_void;
    logic out_err;
    logic out_pend;
    logic valid;
    logic o_first;
    logic o_last;
    logic o_void;
    logic o_err;
    logic [LAT-1:0] rdy_pipe;
    logic in_ready;
  } trd_core_state_type;

  trd_core_state_type st_r;
  trd_core_state_type st_nxt;

  logic [31:0] lane_dword;
  logic take;

  ////////////////////////////////////////////////////////////////////////////
  // lane order

  trd_lane_order u_lane (
    .dword_in(tl_dword),
    .payload_sel(st_r.phase == TRD_PH_PAY),
    .dword_out(lane_dword)
  );

  assign take = st_r.in_ready && tl_dword_valid;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [2:0] idx_now;
    logic four_now;
    logic msg_now;
    logic data_now;
    logic last_hdr;
    logic bit2;
    idx_now = 3'h0;
    four_now = 1'b0;
    msg_now = 1'b0;
    data_now = 1'b0;
    last_hdr = 1'b0;
    bit2 = 1'b0;
    st_nxt = st_r;
    st_nxt.rdy_pipe = {st_r.rdy_pipe[LAT-2:0], rx_sink_accept};

    // a word shown in a ready cycle is taken by the sink
    if (st_r.valid) begin
      st_nxt.out_pend = 1'b0;
    end

    // hand a finished word to the output stage
    if (st_r.acc_done && !st_nxt.out_pend) begin
      st_nxt.out_data = st_r.acc;
      st_nxt.out_first = st_r.acc_first;
      st_nxt.out_last = st_r.acc_last;
      st_nxt.out_void = (K == 4) && st_r.acc_last && (st_r.cnt <= VOID_CNT); // [R13]
      st_nxt.out_err = st_r.acc_err;
      st_nxt.out_pend = 1'b1;
      st_nxt.acc = '0;
      st_nxt.cnt = '0;
      st_nxt.acc_first = 1'b0;
      st_nxt.acc_last = 1'b0;
      st_nxt.acc_err = 1'b0;
      st_nxt.acc_done = 1'b0;
    end

    if (take) begin
      // pad slots stay zero; the sink must not read them
      st_nxt.acc[32*st_r.cnt +: 32] = lane_dword; // [R6]
      st_nxt.cnt = st_r.cnt + ONE_CNT;
      if (tl_dword_first) begin
        st_nxt.acc_first = 1'b1; // [R11]
        st_nxt.phase = TRD_PH_HDR;
      end
      if (st_r.phase == TRD_PH_HDR || tl_dword_first) begin
        idx_now = tl_dword_first ? 3'h0 : st_r.hdr_idx;
        msg_now = tl_dword_first ?
          (tl_dword[`TRD_MSG_HI:`TRD_MSG_LO] == `TRD_MSG_CODE) : st_r.hdr_msg;
        // messages always take the four-dword mapping
        four_now = tl_dword_first ?
          (tl_dword[`TRD_FMT_FOUR_BIT] || msg_now) : st_r.hdr_four; // [R1]
        data_now = tl_dword_first ? tl_dword[`TRD_FMT_DATA_BIT] : st_r.has_data;
        st_nxt.hdr_msg = msg_now;
        st_nxt.hdr_four = four_now;
        st_nxt.has_data = data_now;
        st_nxt.hdr_idx = idx_now + 3'h1;
        // header byte 2 passes untouched; translation bits raise nothing
        // [R9]
        last_hdr = (idx_now == (four_now ? `TRD_HDR_LAST_FOUR : `TRD_HDR_LAST_THREE));
        if (last_hdr) begin
          // request address and completion lower address share bit 2
          bit2 = tl_dword[`TRD_QW_ADDR_BIT]; // [R7] [R8]
          // a message has no usable address: start on a qword boundary
          st_nxt.align = msg_now ? 1'b0 : bit2; // [R4]
          if (data_now && !tl_dword_last) begin
            st_nxt.phase = (st_nxt.cnt[0] != st_nxt.align) ?
              TRD_PH_PAD : TRD_PH_PAY; // [R5]
          end
        end
      end
      if (tl_ecc_err) begin
        st_nxt.acc_err = 1'b1; // [R17]
      end
      if (tl_dword_last) begin
        // an early end after an ecc error closes the packet just the same
        st_nxt.acc_last = 1'b1; // [R12]
        st_nxt.acc_done = 1'b1;
        st_nxt.phase = TRD_PH_HDR;
      end
      if (st_nxt.cnt == K_CNT) begin
        st_nxt.acc_done = 1'b1;
      end
    end else if (st_r.phase == TRD_PH_PAD && !st_r.acc_done) begin
      // skip one dword slot so the payload lands at its byte address
      st_nxt.cnt = st_r.cnt + ONE_CNT; // [R5]
      st_nxt.phase = TRD_PH_PAY;
      if (st_nxt.cnt == K_CNT) begin
        st_nxt.acc_done = 1'b1;
      end
    end

    // at least one bubble per word while the packer hands over, more while the output word waits; no extra buffer
    st_nxt.in_ready = !st_nxt.acc_done && (st_nxt.phase != TRD_PH_PAD);

    // valid only in cycles that accept opened two cycles before
    st_nxt.valid = st_nxt.out_pend && st_nxt.rdy_pipe[LAT-1]; // [R15] [R16]
    st_nxt.o_first = st_nxt.valid && st_nxt.out_first; // [R11]
    st_nxt.o_last = st_nxt.valid && st_nxt.out_last; // [R12]
    st_nxt.o_void = st_nxt.valid && st_nxt.out_void; // [R13]
    st_nxt.o_err = st_nxt.valid && st_nxt.out_err; // [R17]
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign tl_dword_ready = st_r.in_ready;
  assign rx_stream_payload = st_r.out_data;
  assign rx_packet_first = st_r.o_first;
  assign rx_packet_last = st_r.o_last;
  assign rx_upper_qword_void = st_r.o_void;
  assign rx_word_valid = st_r.valid;
  assign rx_uncorrectable_flag = st_r.o_err;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic in_pkt_r;

  always_ff @(posedge mclk) begin
    if (srst) begin
      in_pkt_r <= 1'b0;
    end else if (rx_word_valid && rx_packet_last) begin
      in_pkt_r <= 1'b0;
    end else if (rx_word_valid && rx_packet_first) begin
      in_pkt_r <= 1'b1;
    end
  end

  chk_valid_ready_cycle: assert property ( // [R15]
    @(posedge mclk) disable iff (srst)
    rx_word_valid |-> $past(rx_sink_accept, 2))
    else $error("valid outside a ready cycle");

  chk_valid_drop_bound: assert property ( // [R16]
    @(posedge mclk) disable iff (srst)
    $fell(rx_sink_accept) |-> ##[0:2] !rx_word_valid)
    else $error("valid held too long after accept fell");

  chk_valid_return_bound: assert property ( // [R16]
    @(posedge mclk) disable iff (srst)
    ($past(rx_sink_accept) && rx_sink_accept && st_r.out_pend && !rx_word_valid)
      |=> rx_word_valid)
    else $error("pending word not shown after accept returned");

  chk_first_opens_pkt: assert property ( // [R11]
    @(posedge mclk) disable iff (srst)
    (rx_packet_first |-> rx_word_valid) and
    (rx_word_valid && rx_packet_first |-> !in_pkt_r))
    else $error("first flag inside a packet or without valid");

  chk_last_closes_pkt: assert property ( // [R12]
    @(posedge mclk) disable iff (srst)
    (rx_packet_last |-> rx_word_valid) and
    (rx_word_valid && !rx_packet_first |-> in_pkt_r))
    else $error("word outside a packet or last without valid");

  chk_void_upper_only: assert property ( // [R13]
    @(posedge mclk) disable iff (srst)
    rx_upper_qword_void |-> (rx_packet_last && (DATA_W == 128)))
    else $error("void flag off the last word or in 64-bit mode");

  chk_err_with_valid: assert property ( // [R17]
    @(posedge mclk) disable iff (srst)
    rx_uncorrectable_flag |-> rx_word_valid)
    else $error("error flag without valid");

  chk_pad_parity: assert property ( // [R5]
    @(posedge mclk) disable iff (srst)
    (st_r.phase != TRD_PH_PAY) ##1 (st_r.phase == TRD_PH_PAY)
      |-> (st_r.cnt[0] == st_r.align))
    else $error("payload starts in the wrong dword of its qword");

  chk_msg_four_dword: assert property ( // [R1]
    @(posedge mclk) disable iff (srst)
    (take && tl_dword_first && (tl_dword[`TRD_MSG_HI:`TRD_MSG_LO] == `TRD_MSG_CODE))
      |=> st_r.hdr_four)
    else $error("message not mapped with four header dwords");

  chk_word_held: assert property ( // [R15]
    @(posedge mclk) disable iff (srst)
    (st_r.out_pend && !rx_word_valid) |=> $stable(rx_stream_payload))
    else $error("pending word changed before transfer");

  cov_padded_payload: cover property (
    @(posedge mclk) disable iff (srst)
    st_r.phase == TRD_PH_PAD);

  cov_back_to_back: cover property (
    @(posedge mclk) disable iff (srst)
    rx_word_valid ##1 rx_word_valid);

  cov_void_word: cover property (
    @(posedge mclk) disable iff (srst)
    rx_upper_qword_void);

  cov_error_word: cover property (
    @(posedge mclk) disable iff (srst)
    rx_uncorrectable_flag ##[1:8] rx_packet_last);

endmodule : trd_rx_framer

`default_nettype wire

// File: testbench/trd_sink_model.sv
// application-side sink model that throttles the receive stream
`timescale 1ns/1ns
`default_nettype none

module trd_sink_model (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // percentage of cycles with accept low
  input wire logic [6:0] stall_pct,
  // ready towards the framer
  output logic rx_sink_accept
);
  // the sink cannot refuse a valid word, so it only throttles two cycles ahead
  always @(posedge mclk) begin
    if (srst) begin
      rx_sink_accept <= 1'b0;
    end else begin
      rx_sink_accept <= (7'($urandom % 100) >= stall_pct);
    end
  end
endmodule : trd_sink_model

`default_nettype wire

// File: testbench/tb_top.sv
// self-checking bench for the receive stream framer in 64-bit and 128-bit mode
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  // clock starts low so no false falling edge reaches the monitor at time zero
  logic mclk = 1'b0;
  logic srst, tl_dword_valid, tl_dword_first, tl_dword_last, tl_ecc_err, tl_dword_ready;
  logic wide, tl_dword_ready_w, rx_packet_first_w, rx_packet_last_w, rx_upper_qword_void_w;
  logic rx_word_valid_w, rx_uncorrectable_flag_w, rx_sink_accept_w;
  logic [127:0] rx_stream_payload_w;
  logic [31:0] tl_dword;
  logic [63:0] rx_stream_payload;
  logic rx_packet_first, rx_packet_last, rx_upper_qword_void, rx_word_valid;
  logic rx_uncorrectable_flag, rx_sink_accept;
  logic [6:0] stall_pct;
  logic [131:0] exp_q[$], exp_w[$];
  logic [1:0] acc_h, acc_v;
  logic [7:0] kinds[9] = '{8'h40, 8'h60, 8'h4A, 8'h70, 8'h50, 8'h00, 8'h20, 8'h0A, 8'h44};
  int fails, checks, np, ex;

  trd_rx_framer #(.DATA_W(64)) dut (.mclk(mclk), .srst(srst), .tl_dword(tl_dword),
    .tl_dword_valid(tl_dword_valid && !wide), .tl_dword_first(tl_dword_first),
    .tl_dword_last(tl_dword_last), .tl_ecc_err(tl_ecc_err), .tl_dword_ready(tl_dword_ready),
    .rx_stream_payload(rx_stream_payload), .rx_packet_first(rx_packet_first),
    .rx_packet_last(rx_packet_last), .rx_upper_qword_void(rx_upper_qword_void),
    .rx_word_valid(rx_word_valid), .rx_uncorrectable_flag(rx_uncorrectable_flag),
    .rx_sink_accept(rx_sink_accept));
  trd_sink_model sink (.mclk(mclk), .srst(srst), .stall_pct(stall_pct),
    .rx_sink_accept(rx_sink_accept));
  // the 128-bit instance takes the same dwords while wide is set
  trd_rx_framer #(.DATA_W(128)) dut_w (.mclk(mclk), .srst(srst), .tl_dword(tl_dword),
    .tl_dword_valid(tl_dword_valid && wide), .tl_dword_first(tl_dword_first),
    .tl_dword_last(tl_dword_last), .tl_ecc_err(tl_ecc_err), .tl_dword_ready(tl_dword_ready_w),
    .rx_stream_payload(rx_stream_payload_w), .rx_packet_first(rx_packet_first_w),
    .rx_packet_last(rx_packet_last_w), .rx_upper_qword_void(rx_upper_qword_void_w),
    .rx_word_valid(rx_word_valid_w), .rx_uncorrectable_flag(rx_uncorrectable_flag_w),
    .rx_sink_accept(rx_sink_accept_w));
  trd_sink_model sink_w (.mclk(mclk), .srst(srst), .stall_pct(stall_pct),
    .rx_sink_accept(rx_sink_accept_w));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp_word(input logic [131:0] e, input logic [131:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp_word

  task automatic cmp_bit(input logic e, input logic g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp_bit

  task automatic end_sim;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  // valid stays up between packets so back-to-back dwords never toggle it twice
  task automatic put(input logic [31:0] d, input logic f, input logic l, input logic e);
    int n;
    tl_dword <= d;
    tl_dword_first <= f;
    tl_dword_last <= l;
    tl_ecc_err <= e;
    tl_dword_valid <= 1'b1;
    n = 0;
    @(negedge mclk);
    while ((wide ? tl_dword_ready_w : tl_dword_ready) !== 1'b1) begin
      n++;
      if (n > 2000) begin
        fails++;
        end_sim();
      end
      @(negedge mclk);
    end
    @(posedge mclk);
  endtask : put

  // builds the expected stream words first, then hands the dwords over
  task automatic send_pkt(input logic [7:0] top, input int np, input int ex);
    logic [31:0] d[$];
    logic [31:0] s[$];
    logic e[$];
    int nh;
    logic al;
    int k;
    int u;
    logic [131:0] w;
    d.push_back({top, 24'($urandom)});
    nh = (top[5] || top[4:3] == 2'b10) ? 4 : 3;
    for (int i = 1; i < nh + np; i++) d.push_back($urandom);
    al = (top[4:3] == 2'b10) ? 1'b0 : d[nh-1][2];
    for (int i = 0; i < nh; i++) begin
      s.push_back(d[i]);
      e.push_back(i == ex);
    end
    if (np > 0 && (s.size() % 2) != int'(al)) begin
      s.push_back(32'h0);
      e.push_back(1'b0);
    end
    for (int i = nh; i < nh + np; i++) begin
      s.push_back({d[i][7:0], d[i][15:8], d[i][23:16], d[i][31:24]});
      e.push_back(i == ex);
    end
    k = wide ? 4 : 2;
    u = (s.size() - 1) % k + 1;
    while (s.size() % k) begin
      s.push_back(32'h0);
      e.push_back(1'b0);
    end
    for (int i = 0; i < s.size(); i += k) begin
      w = '0;
      for (int j = 0; j < k; j++) begin
        w[32*j +: 32] = s[i+j];
        w[131] = w[131] | e[i+j];
      end
      // void only on a 128-bit last word whose upper qword is unused
      w[130:128] = {wide && i + k == s.size() && u <= 2, i + k == s.size(), i == 0};
      if (wide) begin
        exp_w.push_back(w);
      end else begin
        exp_q.push_back(w);
      end
    end
    for (int i = 0; i < nh + np; i++) put(d[i], i == 0, i == nh + np - 1, i == ex);
  endtask : send_pkt

  ////////////////////////////////////////////////////////////////////////////
  // outputs are registered, so the falling edge sees each word exactly once
  initial begin
    acc_h = 2'b00;
    acc_v = 2'b00;
    forever begin
      @(negedge mclk);
      if (rx_word_valid === 1'b1) begin
        cmp_bit(1'b1, acc_h[1]);
        cmp_word((exp_q.size() > 0) ? exp_q.pop_front() : 'x, {rx_uncorrectable_flag,
          rx_upper_qword_void, rx_packet_last, rx_packet_first, 64'h0,
          rx_stream_payload});
      end else begin
        cmp_bit(1'b0, rx_packet_first | rx_packet_last | rx_uncorrectable_flag);
      end
      if (rx_word_valid_w === 1'b1) begin
        cmp_bit(1'b1, acc_v[1]);
        cmp_word((exp_w.size() > 0) ? exp_w.pop_front() : 'x, {rx_uncorrectable_flag_w,
          rx_upper_qword_void_w, rx_packet_last_w, rx_packet_first_w,
          rx_stream_payload_w});
      end else begin
        cmp_bit(1'b0, rx_packet_first_w | rx_packet_last_w | rx_uncorrectable_flag_w |
          rx_upper_qword_void_w);
      end
      acc_h = {acc_h[0], rx_sink_accept};
      acc_v = {acc_v[0], rx_sink_accept_w};
    end
  end

  initial begin
    void'($urandom(32'hBFE09DAA));
    srst = 1'b1;
    tl_dword = 32'h0;
    tl_dword_valid = 1'b0;
    tl_dword_first = 1'b0;
    tl_dword_last = 1'b0;
    tl_ecc_err = 1'b0;
    wide = 1'b0;
    stall_pct = 7'h00;
    fails = 0;
    checks = 0;
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    // each width in turn: every packet kind at full accept, then throttled with errors
    for (int w = 0; w < 2; w++) begin
      wide <= w[0];
      stall_pct <= 7'h00;
      @(posedge mclk);
      // random address bit 2 and translation bits
      for (int r = 0; r < 4; r++) begin
        foreach (kinds[k]) send_pkt(kinds[k], kinds[k][6] ? 1 + r : 0, -1);
      end
      // throttled sink with buffer errors on random dwords
      stall_pct <= 7'h28;
      for (int r = 0; r < 40; r++) begin
        np = 1 + $urandom % 5;
        ex = ($urandom % 3 == 0) ? $urandom % (np + 3) : -1;
        send_pkt(kinds[$urandom % 5], np, ex);
      end
      tl_dword_valid <= 1'b0;
      stall_pct <= 7'h00;
      for (int n = 0; n < 500 && exp_q.size() + exp_w.size() > 0; n++) @(posedge mclk);
      if (exp_q.size() + exp_w.size() > 0) begin
        fails++;
      end
    end
    end_sim();
  end
endmodule : tb_top

`default_nettype wire
